/* File: rtl/slave_data_port.sv */
// Slave data port: output drive, data strobe, input sampling, inversion and filtering.
`timescale 1ns/1ps
module slave_data_port
    import slave_data_port_pkg::*;
#(
    parameter int BLOCK_CNT       = BLOCK_CYCLES,
    parameter int FILTER_BASE_CNT = FILTER_BASE_CYCLES
)
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB register port.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Protocol events.
    input  wire logic        exch_req,
    input  wire logic [3:0]  exch_out_data,
    input  wire logic        delete_addr,
    input  wire logic        write_param,
    // Port pins.
    input  wire logic [3:0]  in_pin,
    input  wire logic        p1_pin,
    output logic      [3:0]  out_pin_oe,
    output logic             strobe_oe,
    // Input data for the slave response.
    output logic      [3:0]  in_data,
    output logic             in_data_valid,
    output logic             exchange_disable
);

    port_cfg_s             cfg_r;
    logic [3:0]            out_reg_r;
    logic                  exch_dis_r;
    logic                  init_pending_r;
    logic                  float_r;
    seq_state_e            seq_state_r;
    seq_state_e            seq_state_nxt;
    logic [SEQ_CNT_W-1:0]  seq_cnt_r;
    logic [SEQ_CNT_W-1:0]  seq_cnt_nxt;
    logic [4:0]            pin_meta_r;
    logic [4:0]            pin_sync_r;
    logic [3:0]            inv_data;
    logic [3:0]            filt_data;
    logic [3:0]            raw_cap_r;
    logic [3:0]            use_filt;
    logic [3:0]            in_data_r;
    logic                  in_valid_r;
    logic                  sample_d_r;
    logic [3:0]            oe_r;
    logic                  strobe_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic                  clear_start;
    logic                  data_start;
    logic                  sample_done;
    logic                  sample_take;
    logic                  block_busy;
    logic                  cycle_mode;
    logic                  p1_level;
    logic                  apb_setup;
    logic                  apb_write;
    logic [31:0]           rd_data;
    logic                  rd_hit;

    // Pin inputs pass two flip-flops before any logic reads them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {p1_pin, in_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign p1_level   = pin_sync_r[4];
    assign cycle_mode = (cfg_r.input_filter_time_code == TIME_CODE_CYCLE);

    // Sequence starts: reset and delete always, exchanges only while enabled and idle.
    assign clear_start = delete_addr | init_pending_r;
    assign data_start  = exch_req & ~exch_dis_r & ~clear_start
                         & (seq_state_r == SEQ_IDLE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_pending_r <= 1'b1;
        end else begin
            init_pending_r <= 1'b0;
        end
    end

    // Disable flag: set by reset and delete, cleared by a parameter write; set wins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exch_dis_r <= 1'b1;
        end else if (delete_addr) begin
            exch_dis_r <= 1'b1;
        end else if (write_param) begin
            exch_dis_r <= 1'b0;
        end
    end

    // Output register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg_r <= OUT_RESET;
        end else if (clear_start) begin
            out_reg_r <= OUT_RESET;
        end else if (data_start) begin
            out_reg_r <= exch_out_data;
        end
    end

    // Driver float control: multiplexed mode floats from setup until the input sample.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            float_r <= 1'b1;
        end else if (clear_start) begin
            float_r <= 1'b1;
        end else if (data_start) begin
            float_r <= cfg_r.multiplex_data;
        end else if (sample_done && !exch_dis_r) begin
            float_r <= 1'b0;
        end
    end

    // Strobe sequence: setup time with data driven outside multiplexed mode, then the low strobe pulse.
    always_comb begin
        seq_state_nxt = seq_state_r;
        seq_cnt_nxt   = seq_cnt_r + 1'b1;
        if (clear_start || data_start) begin
            seq_state_nxt = SEQ_SETUP;
            seq_cnt_nxt   = '0;
        end else begin
            unique case (seq_state_r)
                SEQ_IDLE: begin
                    seq_cnt_nxt = '0;
                end
                SEQ_SETUP: begin
                    if (seq_cnt_r == SEQ_CNT_W'(SETUP_CYCLES - 1)) begin
                        seq_state_nxt = SEQ_STROBE;
                        seq_cnt_nxt   = '0;
                    end
                end
                SEQ_STROBE: begin
                    if (seq_cnt_r == SEQ_CNT_W'(STROBE_CYCLES - 1)) begin
                        seq_state_nxt = SEQ_IDLE;
                        seq_cnt_nxt   = '0;
                    end
                end
                default: begin
                    seq_state_nxt = SEQ_IDLE;
                    seq_cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_state_r <= SEQ_IDLE;
            seq_cnt_r   <= '0;
        end else begin
            seq_state_r <= seq_state_nxt;
            seq_cnt_r   <= seq_cnt_nxt;
        end
    end

    // Pin drivers; an output bit at zero pulls its pin low unless the driver floats.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_r     <= '0;
            strobe_r <= 1'b0;
        end else begin
            oe_r     <= ~out_reg_r & {CH_NUM{~float_r}};
            strobe_r <= (seq_state_nxt == SEQ_STROBE);
        end
    end

    // Input sample point after new output data, and the bus-cycle blocking window.
    interval_timer u_sample_tmr (
        .clk      (clk),
        .rst_b    (rst_b),
        .load     (data_start),
        .load_val (TMR_W'(SAMPLE_CYCLES)),
        .busy     (),
        .done     (sample_done)
    );

    assign sample_take = sample_done & ~exch_dis_r & ~(cycle_mode & block_busy);

    interval_timer u_block_tmr (
        .clk      (clk),
        .rst_b    (rst_b),
        .load     (sample_take & cycle_mode),
        .load_val (TMR_W'(BLOCK_CNT)),
        .busy     (block_busy),
        .done     ()
    );

    // Input inversion ahead of the filters.
    assign inv_data = cfg_r.joint_invert ? ~pin_sync_r[3:0]
                    : pin_sync_r[3:0] ^ cfg_r.input_invert_select;

    for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_filter
        input_debounce #(
            .BASE_CYCLES (FILTER_BASE_CNT)
        ) u_debounce (
            .clk        (clk),
            .rst_b      (rst_b),
            .d          (inv_data[ch]),
            .time_code  (cfg_r.input_filter_time_code),
            .sample_evt (sample_take),
            .q          (filt_data[ch])
        );
    end

    assign use_filt = cfg_r.input_filter_enable
                      & {CH_NUM{~(cfg_r.filter_by_pin_flag & p1_level)}};

    // Input register, loaded one cycle after the sample so the filters have settled.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            raw_cap_r  <= '0;
            sample_d_r <= 1'b0;
            in_data_r  <= '0;
            in_valid_r <= 1'b0;
        end else begin
            sample_d_r <= sample_take;
            in_valid_r <= sample_d_r;
            if (sample_take) begin
                raw_cap_r <= inv_data;
            end
            if (sample_d_r) begin
                in_data_r <= (use_filt & filt_data) | (~use_filt & raw_cap_r);
            end
        end
    end

    // APB slave: answers in the first access cycle, unmapped addresses flag an error.
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready_r & pwrite;

    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case (paddr)
            ADDR_CONFIG: begin
                rd_data[CFG_MUX_BIT]      = cfg_r.multiplex_data;
                rd_data[CFG_JOINT_BIT]    = cfg_r.joint_invert;
                rd_data[CFG_PIN_FILT_BIT] = cfg_r.filter_by_pin_flag;
            end
            ADDR_INVERT: begin
                rd_data[3:0] = cfg_r.input_invert_select;
            end
            ADDR_FILTER_EN: begin
                rd_data[3:0] = cfg_r.input_filter_enable;
            end
            ADDR_TIME_CODE: begin
                rd_data[2:0] = cfg_r.input_filter_time_code;
            end
            ADDR_STATUS: begin
                rd_data[ST_OUT_LSB +: 4] = out_reg_r;
                rd_data[ST_IN_LSB +: 4]  = in_data_r;
                rd_data[ST_DISABLE_BIT]  = exch_dis_r;
                rd_data[ST_BUSY_BIT]     = (seq_state_r != SEQ_IDLE);
                rd_data[ST_FLOAT_BIT]    = float_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup & ~rd_hit;
            if (apb_setup && !pwrite) begin
                prdata_r <= rd_data;
            end else if (apb_setup) begin
                prdata_r <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r <= CFG_RESET;
        end else if (apb_write) begin
            unique case (paddr)
                ADDR_CONFIG: begin
                    cfg_r.multiplex_data     <= pwdata[CFG_MUX_BIT];
                    cfg_r.joint_invert       <= pwdata[CFG_JOINT_BIT];
                    cfg_r.filter_by_pin_flag <= pwdata[CFG_PIN_FILT_BIT];
                end
                ADDR_INVERT: begin
                    cfg_r.input_invert_select <= pwdata[3:0];
                end
                ADDR_FILTER_EN: begin
                    cfg_r.input_filter_enable <= pwdata[3:0];
                end
                ADDR_TIME_CODE: begin
                    cfg_r.input_filter_time_code <= pwdata[2:0];
                end
                default: begin
                    cfg_r <= cfg_r;
                end
            endcase
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign out_pin_oe       = oe_r;
    assign strobe_oe        = strobe_r;
    assign in_data          = in_data_r;
    assign in_data_valid    = in_valid_r;
    assign exchange_disable = exch_dis_r;

endmodule

/* File: rtl/slave_data_port_pkg.sv */
// Shared constants, register map and types of the slave data port.
package slave_data_port_pkg;

    localparam int CLK_PERIOD_PS = 8000;

    localparam int T_SETUP_NS       = 500;
    localparam int T_STROBE_NS      = 5500;
    localparam int T_SAMPLE_NS      = 12000;
    localparam int T_BLOCK_NS       = 256000;
    localparam int T_FILTER_BASE_NS = 128000;

    localparam int SETUP_CYCLES       = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYCLES      = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SAMPLE_CYCLES      = (T_SAMPLE_NS * 1000) / CLK_PERIOD_PS;
    localparam int BLOCK_CYCLES       = (T_BLOCK_NS * 1000) / CLK_PERIOD_PS;
    localparam int FILTER_BASE_CYCLES = (T_FILTER_BASE_NS * 1000) / CLK_PERIOD_PS;

    localparam int CH_NUM     = 4;
    localparam int SEQ_CNT_W  = 10;
    localparam int TMR_W      = 16;
    localparam int FILT_CNT_W = 21;

    localparam logic [11:0] ADDR_CONFIG    = 12'h000;
    localparam logic [11:0] ADDR_INVERT    = 12'h004;
    localparam logic [11:0] ADDR_FILTER_EN = 12'h008;
    localparam logic [11:0] ADDR_TIME_CODE = 12'h00C;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;

    localparam int CFG_MUX_BIT      = 0;
    localparam int CFG_JOINT_BIT    = 1;
    localparam int CFG_PIN_FILT_BIT = 2;
    localparam int ST_OUT_LSB       = 0;
    localparam int ST_IN_LSB        = 4;
    localparam int ST_DISABLE_BIT   = 8;
    localparam int ST_BUSY_BIT      = 9;
    localparam int ST_FLOAT_BIT     = 10;

    localparam logic [3:0] OUT_RESET        = 4'hF;
    localparam logic [3:0] INVERT_RESET     = 4'h0;
    localparam logic [3:0] FILTER_EN_RESET  = 4'h0;
    localparam logic [2:0] TIME_CODE_RESET  = 3'h0;
    localparam logic [2:0] TIME_CODE_CYCLE  = 3'h7;

    typedef struct packed {
        logic       filter_by_pin_flag;
        logic       joint_invert;
        logic       multiplex_data;
        logic [3:0] input_invert_select;
        logic [3:0] input_filter_enable;
        logic [2:0] input_filter_time_code;
    } port_cfg_s;

    localparam port_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, INVERT_RESET, FILTER_EN_RESET,
                                        TIME_CODE_RESET};

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETUP, SEQ_STROBE} seq_state_e;

endpackage

/* File: rtl/interval_timer.sv */
// Loadable down counter that flags the end of an interval.
`timescale 1ns/1ps
module interval_timer
    import slave_data_port_pkg::*;
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Control.
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] load_val,
    // Status.
    output logic                  busy,
    output logic                  done
);

    logic [TMR_W-1:0] count_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_val;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign busy = (count_r != '0);
    assign done = (count_r == TMR_W'(1)) && !load;

endmodule

/* File: rtl/input_debounce.sv */
// One input channel filter with a time mode and a bus-cycle mode.
`timescale 1ns/1ps
module input_debounce
    import slave_data_port_pkg::*;
#(
    parameter int BASE_CYCLES = FILTER_BASE_CYCLES
)
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Input level and filter setup.
    input  wire logic       d,
    input  wire logic [2:0] time_code,
    input  wire logic       sample_evt,
    // Filtered level.
    output logic            q
);

    logic [FILT_CNT_W-1:0] cnt_r;
    logic [FILT_CNT_W-1:0] limit;
    logic                  prev_r;
    logic                  q_r;
    logic                  cycle_mode;

    assign cycle_mode = (time_code == TIME_CODE_CYCLE);
    assign limit      = FILT_CNT_W'(BASE_CYCLES) << time_code;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= '0;
            prev_r <= 1'b0;
            q_r    <= 1'b0;
        end else if (cycle_mode) begin
            cnt_r <= '0;
            if (sample_evt) begin
                prev_r <= d;
                if (d == prev_r) begin
                    q_r <= d;
                end
            end
        end else if (d == q_r) begin
            cnt_r <= '0;
        end else if (cnt_r >= limit - 1'b1) begin
            q_r   <= d;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign q = q_r;

endmodule

/* File: test/port_devices.sv */
// Binary sensors and actuators standing on the data port pins.
`timescale 1ns/1ps
module port_devices (
    // Sensor levels and wiring mode.
    input  wire logic [3:0] sensor_level,
    input  wire logic       wired_mux,
    // Port pins.
    input  wire logic [3:0] out_pin_oe,
    output logic      [3:0] in_pin
);
    // Pull-ups hold released pins high; a driven output pulls its wired input low.
    assign in_pin = wired_mux ? (sensor_level & ~out_pin_oe) : sensor_level;
endmodule

/* File: test/slave_data_port_properties.sv */
// Concurrent checks of the slave data port at its ports.
`timescale 1ns/1ps
module slave_data_port_properties
    import slave_data_port_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB writes that set the mode.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    // Events and pins.
    input  wire logic        delete_addr,
    input  wire logic        write_param,
    input  wire logic [3:0]  out_pin_oe,
    input  wire logic        strobe_oe,
    input  wire logic        in_data_valid,
    input  wire logic        exchange_disable
);
    logic        mux_r;
    logic        strobe_q_r;
    logic [9:0]  len_r;
    logic [11:0] since_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == ADDR_CONFIG) begin
            mux_r <= pwdata[CFG_MUX_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            len_r <= 10'h000;
        end else begin
            len_r <= strobe_oe ? len_r + 10'h001 : 10'h000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_q_r <= 1'b0;
            since_r    <= 12'hFFF;
        end else begin
            strobe_q_r <= strobe_oe;
            if (strobe_oe && !strobe_q_r) begin
                since_r <= 12'h001;
            end else if (since_r != 12'hFFF) begin
                since_r <= since_r + 12'h001;
            end
        end
    end

    property p_strobe_width;
        $fell(strobe_oe) |-> len_r == 10'(STROBE_CYCLES);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

    property p_setup;
        $rose(strobe_oe) && !mux_r |-> out_pin_oe == $past(out_pin_oe, 13);
    endproperty
    a_setup: assert property (p_setup) else $error("output data not settled");

    property p_mux_float;
        $rose(strobe_oe) && mux_r |-> out_pin_oe == 4'h0 && $past(out_pin_oe, 13) == 4'h0;
    endproperty
    a_mux_float: assert property (p_mux_float) else $error("driver not floated");

    property p_mux_hold;
        $fell(strobe_oe) && mux_r |-> (out_pin_oe == 4'h0) [*8] ##5 out_pin_oe == 4'h0;
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("driver back too soon");

    property p_delete;
        delete_addr |=> exchange_disable ##1 out_pin_oe == 4'h0;
    endproperty
    a_delete: assert property (p_delete) else $error("delete not applied");

    property p_delete_strobe;
        delete_addr |-> ##[13:75] $rose(strobe_oe);
    endproperty
    a_delete_strobe: assert property (p_delete_strobe) else $error("no strobe");

    property p_param;
        write_param && !delete_addr |=> !exchange_disable;
    endproperty
    a_param: assert property (p_param) else $error("disable not cleared");

    property p_quiet;
        exchange_disable |-> !in_data_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("input while disabled");

    property p_sample_time;
        in_data_valid |-> since_r inside {[12'h523:12'h65B]};
    endproperty
    a_sample_time: assert property (p_sample_time) else $error("sample time wrong");

    c_sample: cover property (in_data_valid);
    c_delete: cover property (delete_addr ##1 exchange_disable);
    c_mux: cover property ($rose(strobe_oe) && mux_r);
endmodule

bind slave_data_port slave_data_port_properties u_props (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .delete_addr(delete_addr),
    .write_param(write_param), .out_pin_oe(out_pin_oe), .strobe_oe(strobe_oe),
    .in_data_valid(in_data_valid), .exchange_disable(exchange_disable)
);

/* File: test/tb_slave_data_port.sv */
// Self-checking bench for the slave data port.
`timescale 1ns/1ps
module tb_slave_data_port import slave_data_port_pkg::*;;
    logic        clk, rst_b, psel, penable, pwrite, exch_req, delete_addr, write_param;
    logic        p1_pin, pready, pslverr, strobe_oe, in_data_valid, exchange_disable;
    logic        mux, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  exch_out_data, in_pin, out_pin_oe, in_data, level;
    int          fails, check_count;

    slave_data_port #(.BLOCK_CNT(2000), .FILTER_BASE_CNT(32)) dut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exch_req(exch_req), .exch_out_data(exch_out_data),
        .delete_addr(delete_addr), .write_param(write_param), .in_pin(in_pin),
        .p1_pin(p1_pin), .out_pin_oe(out_pin_oe), .strobe_oe(strobe_oe),
        .in_data(in_data), .in_data_valid(in_data_valid),
        .exchange_disable(exchange_disable)
    );
    port_devices devs (.sensor_level(level), .wired_mux(mux), .out_pin_oe(out_pin_oe),
                       .in_pin(in_pin));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic req(input logic [3:0] d);
        exch_req <= 1'b1;
        exch_out_data <= d;
        @(posedge clk);
        exch_req <= 1'b0;
    endtask

    task automatic exch(input logic [3:0] d, input logic [3:0] exp, input logic fl);
        int n;
        n = 0;
        req(d);
        repeat (3) @(posedge clk);
        chk("out_pin_oe", out_pin_oe, fl ? 4'h0 : 4'(~d));
        while (in_data_valid !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            close_out();
        end
        chk("in_data", in_data, exp);
        @(posedge clk);
    endtask

    task automatic nov(input int cyc);
        int seen;
        seen = 0;
        repeat (cyc) begin
            @(posedge clk);
            if (in_data_valid !== 1'b0) seen = 1;
        end
        chk("in_data_valid", seen, 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, exch_req, delete_addr, write_param, p1_pin, mux} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        exch_out_data = 4'h0;
        level = 4'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("exchange_disable", exchange_disable, 1'b1);
        chk("out_pin_oe", out_pin_oe, 4'h0);
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk("pslverr", er, 1'b0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk("pslverr", er, 1'b1);
        apb(1'b1, ADDR_TIME_CODE, 32'hFFFFFFFF);
        apb(1'b0, ADDR_TIME_CODE, 32'h0);
        chk("time code", rd, 32'h7);
        apb(1'b1, ADDR_TIME_CODE, 32'h0);
        repeat (800) @(posedge clk);
        req(4'h0);
        nov(1800);
        chk("out_pin_oe", out_pin_oe, 4'h0);
        write_param <= 1'b1;
        @(posedge clk);
        write_param <= 1'b0;
        @(posedge clk);
        chk("exchange_disable", exchange_disable, 1'b0);
        level <= 4'hA;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CONFIG, (i == 2) ? 32'h2 : 32'h0);
            apb(1'b1, ADDR_INVERT, (i == 0) ? 32'h0 : 32'h3);
            exch(4'(i * 5), (i == 2) ? 4'h5 : ((i == 0) ? 4'hA : 4'h9), 1'b0);
        end
        apb(1'b1, ADDR_CONFIG, 32'h1);
        apb(1'b1, ADDR_INVERT, 32'h0);
        mux <= 1'b1;
        level <= 4'hC;
        exch(4'h3, 4'hC, 1'b1);
        mux <= 1'b0;
        apb(1'b1, ADDR_CONFIG, 32'h0);
        apb(1'b1, ADDR_FILTER_EN, 32'h1);
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, ADDR_TIME_CODE, 32'(k));
            level <= {k[0], ~k[0], k[0], ~k[0]};
            exch(4'(k), {k[0], ~k[0], k[0], (k < 6) ? ~k[0] : 1'b0}, 1'b0);
        end
        apb(1'b1, ADDR_CONFIG, 32'h4);
        p1_pin <= 1'b1;
        repeat (700) @(posedge clk);
        level <= 4'h0;
        exch(4'h9, 4'h0, 1'b0);
        p1_pin <= 1'b0;
        apb(1'b1, ADDR_CONFIG, 32'h0);
        apb(1'b1, ADDR_TIME_CODE, 32'h0);
        repeat (100) @(posedge clk);
        apb(1'b1, ADDR_TIME_CODE, 32'h7);
        level <= 4'h1;
        repeat (600) @(posedge clk);
        exch(4'h1, 4'h0, 1'b0);
        req(4'h2);
        nov(1700);
        repeat (600) @(posedge clk);
        exch(4'h3, 4'h1, 1'b0);
        delete_addr <= 1'b1;
        @(posedge clk);
        delete_addr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("exchange_disable", exchange_disable, 1'b1);
        chk("out_pin_oe", out_pin_oe, 4'h0);
        repeat (800) @(posedge clk);
        req(4'h5);
        nov(1700);
        chk("out_pin_oe", out_pin_oe, 4'h0);
        close_out();
    end
endmodule
